// File: rtl/bgcl_top.sv
// Gate command logic: direct inputs, register commands, lockout,
// enable handling with timeout, status and interrupt over AXI4-Lite.
// Assumes direct pins and enable are asynchronous; pull-downs are external.
//
// Chosen here: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module bgcl_top #(
	parameter int TIMEOUT_CYC = bgcl_pkg::TIMEOUT_CYC
) (
	input  wire logic        aclk,              // System clock
	input  wire logic        aresetn,           // Sync reset, low
	input  wire logic        phase_a_high_cmd,  // Direct A high
	input  wire logic        phase_a_low_cmd,   // Direct A low
	input  wire logic        phase_b_high_cmd,  // Direct B high
	input  wire logic        phase_b_low_cmd,   // Direct B low
	input  wire logic        phase_c_high_cmd,  // Direct C high
	input  wire logic        phase_c_low_cmd,   // Direct C low
	input  wire logic        enable_in,         // Output enable pin
	output var  logic [5:0]  gate_out,          // Gate commands AH..CL
	output var  logic        irq,               // Interrupt level
	input  wire logic        s_axi_awvalid,     // AW valid
	output var  logic        s_axi_awready,     // AW ready
	input  wire logic [3:0]  s_axi_awaddr,      // AW address
	input  wire logic        s_axi_wvalid,      // W valid
	output var  logic        s_axi_wready,      // W ready
	input  wire logic [31:0] s_axi_wdata,       // W data
	input  wire logic [3:0]  s_axi_wstrb,       // W strobes
	output var  logic        s_axi_bvalid,      // B valid
	input  wire logic        s_axi_bready,      // B ready
	output var  logic [1:0]  s_axi_bresp,       // B response
	input  wire logic        s_axi_arvalid,     // AR valid
	output var  logic        s_axi_arready,     // AR ready
	input  wire logic [3:0]  s_axi_araddr,      // AR address
	output var  logic        s_axi_rvalid,      // R valid
	input  wire logic        s_axi_rready,      // R ready
	output var  logic [31:0] s_axi_rdata,       // R data
	output var  logic [1:0]  s_axi_rresp        // R response
);
	// ------------------------------------------------------------
	// Input synchronisation
	// ------------------------------------------------------------
	logic [6:0] pins_sync;
	logic [5:0] pin_cmd;
	logic       en_sync;
	// Six direct inputs, one per drive, plus the enable pin in bit 6
	bgcl_sync #(.W(7)) u_sync (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.async_in ({enable_in, phase_a_high_cmd, phase_a_low_cmd,
			phase_b_high_cmd, phase_b_low_cmd, phase_c_high_cmd,
			phase_c_low_cmd}),
		.sync_out (pins_sync)
	);
	assign pin_cmd = pins_sync[5:0];
	assign en_sync = pins_sync[6];

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	logic [5:0]  reg_cmd;
	logic [2:0]  cfg;
	logic        timeout_flag;
	logic        common_fault_flag;
	logic        irq_mask;
	logic        out_active;
	logic [5:0]  drive;
	logic        en_prev;
	logic        en_edge;
	logic [bgcl_pkg::CNT_W-1:0] tmr;
	logic        timer_run;
	logic        timeout_hit;
	logic        st_read;
	logic        clear_faults;
	logic        aw_held;
	logic        w_held;
	logic [3:0]  aw_addr;
	logic [31:0] w_data;
	logic [3:0]  w_strb;
	logic        do_write;

	bgcl_lockout u_lock (
		.pin_cmd (pin_cmd),
		.reg_cmd (reg_cmd),
		.drive   (drive)
	);

	// ------------------------------------------------------------
	// AXI4-Lite write path
	// ------------------------------------------------------------
	assign do_write = aw_held && w_held && !s_axi_bvalid;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held       <= 1'b0;
			w_held        <= 1'b0;
			aw_addr       <= '0;
			w_data        <= '0;
			w_strb        <= '0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
		end else begin
			s_axi_awready <= !aw_held && !s_axi_awready;
			s_axi_wready  <= !w_held && !s_axi_wready;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (do_write) begin
				aw_held <= 1'b0;
				w_held  <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= bgcl_pkg::RESP_OKAY;
		end else if (do_write) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= (aw_addr == bgcl_pkg::ADDR_STATUS ||
				aw_addr[1:0] != 2'h0) ? bgcl_pkg::RESP_SLVERR : bgcl_pkg::RESP_OKAY;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// Control and config: reset 0 leaves register path idle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			reg_cmd  <= bgcl_pkg::CTRL_RESET[5:0];
			cfg      <= bgcl_pkg::CFG_RESET;
			irq_mask <= 1'b0;
		end else if (do_write && w_strb[0]) begin
			unique case (aw_addr)
				bgcl_pkg::ADDR_CTRL:     reg_cmd  <= w_data[5:0];
				bgcl_pkg::ADDR_CONFIG:   cfg      <= w_data[2:0];
				bgcl_pkg::ADDR_IRQ_MASK: irq_mask <= w_data[0];
				default: ;
			endcase
		end
	end

	// ------------------------------------------------------------
	// AXI4-Lite read path
	// ------------------------------------------------------------
	assign st_read = s_axi_arvalid && s_axi_arready &&
		s_axi_araddr == bgcl_pkg::ADDR_STATUS;
	assign clear_faults = st_read && !cfg[bgcl_pkg::CFG_READ_KEEP];
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= '0;
			s_axi_rresp   <= bgcl_pkg::RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rresp   <= bgcl_pkg::RESP_OKAY;
			s_axi_rdata   <= '0;
			unique case (s_axi_araddr)
				bgcl_pkg::ADDR_CTRL:     s_axi_rdata[5:0] <= reg_cmd;
				bgcl_pkg::ADDR_CONFIG:   s_axi_rdata[2:0] <= cfg;
				bgcl_pkg::ADDR_IRQ_MASK: s_axi_rdata[0]   <= irq_mask;
				bgcl_pkg::ADDR_STATUS: begin
					s_axi_rdata[bgcl_pkg::ST_TIMEOUT]    <= timeout_flag;
					s_axi_rdata[bgcl_pkg::ST_OUT_ACTIVE] <= out_active;
					s_axi_rdata[bgcl_pkg::ST_COMMON]     <= common_fault_flag;
				end
				default: s_axi_rresp <= bgcl_pkg::RESP_SLVERR;
			endcase
		end else if (s_axi_rvalid) begin
			if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end else begin
			s_axi_arready <= 1'b1;
		end
	end

	// ------------------------------------------------------------
	// Enable qualification and timeout
	// ------------------------------------------------------------
	assign en_edge     = en_sync != en_prev;
	assign timeout_hit = timer_run && tmr == bgcl_pkg::CNT_W'(TIMEOUT_CYC - 1);
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			en_prev <= 1'b0;
		end else begin
			en_prev <= en_sync;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn || cfg[bgcl_pkg::CFG_ETO_MASK]) begin
			tmr       <= '0;
			timer_run <= 1'b0;
		end else if (en_edge) begin
			tmr       <= '0;
			timer_run <= 1'b1;
		end else if (timeout_hit) begin
			timer_run <= 1'b0;
		end else if (timer_run) begin
			tmr <= tmr + 1'b1;
		end
	end

	// Outputs off until first edge; off again after a stopping timeout
	always_ff @(posedge aclk) begin
		if (!aresetn || cfg[bgcl_pkg::CFG_ETO_MASK]) begin
			out_active <= 1'b0;
		end else if (en_edge) begin
			out_active <= 1'b1;
		end else if (timeout_hit && cfg[bgcl_pkg::CFG_STOP_SEL]) begin
			out_active <= 1'b0;
		end
	end

	// Set beats clear; stop mode also self-clears on the next edge
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			timeout_flag <= 1'b0;
		end else if (timeout_hit) begin
			timeout_flag <= 1'b1;
		end else if (clear_faults ||
			(en_edge && cfg[bgcl_pkg::CFG_STOP_SEL])) begin
			timeout_flag <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			common_fault_flag <= 1'b0;
		end else if (timeout_hit) begin
			common_fault_flag <= 1'b1;
		end else if (clear_faults) begin
			common_fault_flag <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Gate outputs and interrupt
	// ------------------------------------------------------------
	// Direct mode still costs the two sync flops plus one; a true
	// asynchronous bypass belongs in the analogue driver stage.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			gate_out <= '0;
		end else if (cfg[bgcl_pkg::CFG_ETO_MASK]) begin
			gate_out <= en_sync ? drive : '0;
		end else begin
			gate_out <= out_active ? drive : '0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq <= 1'b0;
		end else begin
			irq <= timeout_flag && irq_mask;
		end
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	lockout_phase_a: assert property (@(posedge aclk) disable iff (!aresetn)
		!(gate_out[5] && gate_out[4]))
		else $error("phase A both sides on");
	lockout_req_a: assert property (@(posedge aclk) disable iff (!aresetn)
		(pin_cmd[5] | reg_cmd[5]) && (pin_cmd[4] | reg_cmd[4])
		|=> !gate_out[5] && !gate_out[4])
		else $error("lockout did not force phase off");
	// With pins idle and outputs active in timed mode, a register command without a same-phase pair must pass unchanged
	or_combine_a: assert property (@(posedge aclk) disable iff (!aresetn)
		out_active && !cfg[bgcl_pkg::CFG_ETO_MASK] && pin_cmd == 6'h00 &&
		(reg_cmd & (reg_cmd >> 1) & 6'h15) == 6'h00
		|=> gate_out == $past(reg_cmd))
		else $error("register command not passed");
	direct_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
		cfg[bgcl_pkg::CFG_ETO_MASK] && !en_sync |=> gate_out == 6'h00)
		else $error("direct enable low left outputs on");
	edge_activates_a: assert property (@(posedge aclk) disable iff (!aresetn)
		!cfg[bgcl_pkg::CFG_ETO_MASK] && en_edge |=> out_active)
		else $error("enable edge did not activate");
	stop_timeout_a: assert property (@(posedge aclk) disable iff (!aresetn)
		timeout_hit && cfg[bgcl_pkg::CFG_STOP_SEL] && !cfg[bgcl_pkg::CFG_ETO_MASK] &&
		!en_edge |=> !out_active && timeout_flag)
		else $error("stopping timeout wrong");
	keep_timeout_a: assert property (@(posedge aclk) disable iff (!aresetn)
		timeout_hit && !cfg[bgcl_pkg::CFG_STOP_SEL] && !cfg[bgcl_pkg::CFG_ETO_MASK] &&
		!en_edge |=> $stable(out_active) && timeout_flag)
		else $error("non-stop timeout changed outputs");
	restart_timer_a: assert property (@(posedge aclk) disable iff (!aresetn)
		en_edge && !cfg[bgcl_pkg::CFG_ETO_MASK] |=> tmr == '0)
		else $error("timer not restarted");
	keep_on_read_a: assert property (@(posedge aclk) disable iff (!aresetn)
		st_read && cfg[bgcl_pkg::CFG_READ_KEEP] && timeout_flag && !en_edge
		|=> timeout_flag)
		else $error("suppressed read cleared fault");
	common_fault_a: assert property (@(posedge aclk) disable iff (!aresetn)
		timeout_flag |-> common_fault_flag)
		else $error("common fault flag missing");
endmodule : bgcl_top
`default_nettype wire

// File: rtl/bgcl_pkg.sv
// Constants and register map for the bridge gate command logic.
// Assumes a single 125 MHz clock and an AXI4-Lite master for software.
package bgcl_pkg;
	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam logic [3:0]  ADDR_CTRL     = 4'h0;
	localparam logic [3:0]  ADDR_CONFIG   = 4'h4;
	localparam logic [3:0]  ADDR_STATUS   = 4'h8;
	localparam logic [3:0]  ADDR_IRQ_MASK = 4'hC;
	localparam int          ADDR_W        = 4;
	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int          CFG_ETO_MASK  = 0;
	localparam int          CFG_STOP_SEL  = 1;
	localparam int          CFG_READ_KEEP = 2;
	localparam int          ST_TIMEOUT    = 0;
	localparam int          ST_OUT_ACTIVE = 1;
	localparam int          ST_COMMON     = 15;
	localparam logic [31:0] CTRL_RESET    = 32'h0000_0000;
	localparam logic [2:0]  CFG_RESET     = 3'h0;
	localparam logic [1:0]  RESP_OKAY     = 2'h0;
	localparam logic [1:0]  RESP_SLVERR   = 2'h2;
	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int          CLK_MHZ       = 125;
	localparam int          TIMEOUT_US    = 1000;
	localparam int          TIMEOUT_CYC   = TIMEOUT_US * CLK_MHZ;
	localparam int          CNT_W         = 24;
endpackage : bgcl_pkg

// File: rtl/bgcl_sync.sv
// Two-flop synchroniser for a bank of pin inputs.
// Assumes inputs are asynchronous to aclk.
`timescale 1ns/1ps
`default_nettype none
module bgcl_sync #(
	parameter int W = 1
) (
	input  wire logic         aclk,    // System clock
	input  wire logic         aresetn, // Sync reset, low
	input  wire logic [W-1:0] async_in, // Pin levels
	output var  logic [W-1:0] sync_out  // Synchronised
);
	logic [W-1:0] stage1;
	// Reset low matches the safe off level of the pins
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			stage1   <= '0;
			sync_out <= '0;
		end else begin
			stage1   <= async_in;
			sync_out <= stage1;
		end
	end
endmodule : bgcl_sync
`default_nettype wire

// File: rtl/bgcl_lockout.sv
// Per-phase OR of command sources with cross-conduction lockout.
// Assumes both command vectors are on aclk; bit order AH,AL,BH,BL,CH,CL.
`timescale 1ns/1ps
`default_nettype none
module bgcl_lockout (
	input  wire logic [5:0] pin_cmd, // Synchronised direct commands
	input  wire logic [5:0] reg_cmd, // Register commands
	output var  logic [5:0] drive    // Locked-out request
);
	logic [5:0] req;
	assign req = pin_cmd | reg_cmd;
	genvar p;
	generate
		for (p = 0; p < 3; p++) begin : g_phase
			// Both sides on means neither; avoids shoot-through
			assign drive[2*p+1] = req[2*p+1] & ~req[2*p];
			assign drive[2*p]   = req[2*p]   & ~req[2*p+1];
		end
	endgenerate
endmodule : bgcl_lockout
`default_nettype wire

// File: test/bgcl_host.sv
// Host controller model: drives the six direct command pins and the enable pin.
// Assumes the bench sets the requested levels; pins change only after aclk edges.
`timescale 1ns/1ps
`default_nettype none
module bgcl_host (
	input  wire logic       aclk,    // System clock
	input  wire logic       aresetn, // Sync reset, low
	input  wire logic [5:0] pin_req, // Wanted pin levels AH..CL
	input  wire logic       en_req,  // Wanted enable level
	output var  logic [5:0] pins,    // Direct command pins
	output var  logic       en_pin   // Enable pin
);
	// Pins stay low until the controller is out of reset
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pins   <= 6'h00;
			en_pin <= 1'b0;
		end else begin
			pins   <= pin_req;
			en_pin <= en_req;
		end
	end
endmodule : bgcl_host
`default_nettype wire

// File: test/bgcl_top_tb.sv
// Self-checking bench for the gate command logic, registers over AXI4-Lite.
// Assumes the host model drives the pins; timeout shortened to 50 cycles.
`timescale 1ns/1ps
`default_nettype none
module bgcl_top_tb;
	logic aclk = 1'b0, aresetn = 1'b0, en_req = 1'b0, en_pin, irq;
	logic [5:0] pin_req = 6'h00, pins, gate_out;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b1, arvalid = 1'b0, rready = 1'b1;
	logic awready, wready, bvalid, arready, rvalid;
	logic [3:0] awaddr = 4'h0, araddr = 4'h0;
	logic [31:0] wdata = 32'h0, rdata;
	logic [1:0] bresp, rresp;
	int n_errors = 0, checks = 0, i;
	always #4 aclk = ~aclk;
	bgcl_host bgcl_host_inst (.aclk(aclk), .aresetn(aresetn), .pin_req(pin_req),
		.en_req(en_req), .pins(pins), .en_pin(en_pin));
	bgcl_top #(.TIMEOUT_CYC(50)) bgcl_top_inst (.aclk(aclk), .aresetn(aresetn),
		.phase_a_high_cmd(pins[5]), .phase_a_low_cmd(pins[4]), .phase_b_high_cmd(pins[3]),
		.phase_b_low_cmd(pins[2]), .phase_c_high_cmd(pins[1]), .phase_c_low_cmd(pins[0]),
		.enable_in(en_pin), .gate_out(gate_out), .irq(irq), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp));
	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string m);
		checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("unexpected at %0t: %s seen %h expected %h", $time, m, seen, exp);
		end
	endtask : chk
	task automatic cyc(input int k);
		repeat (k) @(posedge aclk);
	endtask : cyc
	// Answer channels stay ready; only the watchdog ends a wait
	task automatic wchk(input logic [3:0] a, input logic [31:0] dv, input logic [1:0] er);
		awaddr  <= a;
		wdata   <= dv;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		do begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
		end while (!(bvalid && bready));
		chk({30'h0, bresp}, {30'h0, er}, "write response");
	endtask : wchk
	task automatic rchk(input logic [3:0] a, input logic [31:0] msk, input logic [31:0] e,
		input logic [1:0] er);
		araddr  <= a;
		arvalid <= 1'b1;
		do begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'b0;
		end while (!(rvalid && rready));
		chk(rdata & msk, e, "read data");
		chk({30'h0, rresp}, {30'h0, er}, "read response");
	endtask : rchk
	task automatic results();
		$display("checks %0d errors %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : results
	// ------------------------------------------------------------
	// Tests
	// ------------------------------------------------------------
	initial begin
		repeat (20000) @(posedge aclk);
		chk(32'h1, 32'h0, "watchdog");
		results();
	end
	initial begin
		cyc(10);
		aresetn <= 1'b1;
		cyc(2);
		chk(32'(gate_out), 32'h0, "reset outputs");
		rchk(bgcl_pkg::ADDR_CTRL, 32'hFFFF, 32'h0, bgcl_pkg::RESP_OKAY);
		rchk(bgcl_pkg::ADDR_CONFIG, 32'hFFFF, 32'h0, bgcl_pkg::RESP_OKAY);
		wchk(bgcl_pkg::ADDR_CONFIG, 32'h1, bgcl_pkg::RESP_OKAY);
		en_req <= 1'b1;
		for (i = 0; i < 6; i++) begin
			pin_req <= 6'h01 << i;
			cyc(6);
			chk(32'(gate_out), 32'h1 << i, "pin drive");
			pin_req <= 6'h00;
			wchk(bgcl_pkg::ADDR_CTRL, 32'h1 << i, bgcl_pkg::RESP_OKAY);
			cyc(6);
			chk(32'(gate_out), 32'h1 << i, "register drive");
			wchk(bgcl_pkg::ADDR_CTRL, 32'h0, bgcl_pkg::RESP_OKAY);
		end
		// High side from a pin, low side from the register
		for (i = 0; i < 3; i++) begin
			pin_req <= 6'h02 << (2 * i);
			wchk(bgcl_pkg::ADDR_CTRL, 32'h1 << (2 * i), bgcl_pkg::RESP_OKAY);
			cyc(6);
			chk(32'(gate_out), 32'h0, "lockout");
		end
		pin_req <= 6'h00;
		wchk(bgcl_pkg::ADDR_CTRL, 32'h2A, bgcl_pkg::RESP_OKAY);
		cyc(6);
		chk(32'(gate_out), 32'h2A, "enabled");
		en_req <= 1'b0;
		cyc(6);
		chk(32'(gate_out), 32'h0, "enable cut");
		en_req <= 1'b1;
		cyc(6);
		chk(32'(gate_out), 32'h2A, "enable back");
		// Timed enable with stop selected
		wchk(bgcl_pkg::ADDR_CONFIG, 32'h2, bgcl_pkg::RESP_OKAY);
		wchk(bgcl_pkg::ADDR_IRQ_MASK, 32'h1, bgcl_pkg::RESP_OKAY);
		for (i = 0; i < 5; i++) begin
			en_req <= ~en_req;
			cyc(20);
			chk(32'(gate_out), 32'h2A, "timed on");
		end
		chk(32'(irq), 32'h0, "no timeout yet");
		cyc(80);
		chk(32'(gate_out), 32'h0, "timeout stop");
		chk(32'(irq), 32'h1, "timeout irq");
		en_req <= ~en_req;
		cyc(6);
		chk(32'(gate_out), 32'h2A, "reactivated");
		rchk(bgcl_pkg::ADDR_STATUS, 32'h8001, 32'h8000, bgcl_pkg::RESP_OKAY);
		rchk(bgcl_pkg::ADDR_STATUS, 32'h8001, 32'h0, bgcl_pkg::RESP_OKAY);
		chk(32'(irq), 32'h0, "irq cleared");
		// Timeout without stop, masked interrupt, read suppression
		wchk(bgcl_pkg::ADDR_CONFIG, 32'h0, bgcl_pkg::RESP_OKAY);
		wchk(bgcl_pkg::ADDR_IRQ_MASK, 32'h0, bgcl_pkg::RESP_OKAY);
		cyc(80);
		chk(32'(gate_out), 32'h2A, "no stop");
		chk(32'(irq), 32'h0, "irq masked");
		wchk(bgcl_pkg::ADDR_IRQ_MASK, 32'h1, bgcl_pkg::RESP_OKAY);
		cyc(3);
		chk(32'(irq), 32'h1, "irq unmasked");
		wchk(bgcl_pkg::ADDR_CONFIG, 32'h4, bgcl_pkg::RESP_OKAY);
		rchk(bgcl_pkg::ADDR_STATUS, 32'h8001, 32'h8001, bgcl_pkg::RESP_OKAY);
		rchk(bgcl_pkg::ADDR_STATUS, 32'h8001, 32'h8001, bgcl_pkg::RESP_OKAY);
		wchk(bgcl_pkg::ADDR_CONFIG, 32'h0, bgcl_pkg::RESP_OKAY);
		en_req <= ~en_req;
		cyc(6);
		rchk(bgcl_pkg::ADDR_STATUS, 32'h8001, 32'h8001, bgcl_pkg::RESP_OKAY);
		rchk(bgcl_pkg::ADDR_STATUS, 32'h8001, 32'h0, bgcl_pkg::RESP_OKAY);
		chk(32'(irq), 32'h0, "irq after read");
		// Refused accesses store nothing
		wchk(4'h1, 32'h3F, bgcl_pkg::RESP_SLVERR);
		wchk(bgcl_pkg::ADDR_STATUS, 32'h1, bgcl_pkg::RESP_SLVERR);
		rchk(4'h1, 32'hFFFF_FFFF, 32'h0, bgcl_pkg::RESP_SLVERR);
		rchk(bgcl_pkg::ADDR_CTRL, 32'hFFFF_FFFF, 32'h2A, bgcl_pkg::RESP_OKAY);
		results();
	end
endmodule : bgcl_top_tb
`default_nettype wire
